/* File: shared/led_scan_pkg.sv */
package led_scan_pkg;

  // register map
  localparam logic [7:0] MAIN_CTRL_ADDR = 8'hB1;
  localparam logic [7:0] GROUP_BRIGHT_ADDR = 8'hB2;

  // field positions in the main control register
  localparam int DUTY_POS = 6;
  localparam int PSC_POS = 4;
  localparam int HOLD_POS = 3;
  localparam int MAIN_BRIGHT_POS = 0;

  // field positions in the group brightness register
  localparam int SMOOTH_DIS_POS = 7;
  localparam int ODD_BRIGHT_POS = 4;
  localparam int EVEN_BRIGHT_POS = 0;

  // reset values
  localparam logic [1:0] DUTY_RST = 2'h0;
  localparam logic [1:0] PSC_RST = 2'h0;
  localparam logic HOLD_RST = 1'h0;
  localparam logic [2:0] BRIGHT_RST = 3'h4;
  localparam logic SMOOTH_DIS_RST = 1'h0;

  // prescaler divisors of the fast RC oscillator
  localparam logic [6:0] DIV_CODE0 = 7'h40;
  localparam logic [6:0] DIV_CODE1 = 7'h20;
  localparam logic [6:0] DIV_CODE2 = 7'h10;
  localparam logic [6:0] DIV_CODE3 = 7'h08;

  // scan geometry
  localparam logic [3:0] SLOTS_DUTY8 = 4'h8;
  localparam logic [3:0] SLOTS_DUTY9 = 4'h9;
  localparam logic [3:0] SLOTS_DUTY10 = 4'hA;
  localparam logic [2:0] SEGS_DUTY8 = 3'h4;
  localparam logic [2:0] SEGS_DUTY9 = 3'h5;
  localparam logic [2:0] SEGS_DUTY10 = 3'h6;
  localparam int SEG_LINES = 6;
  localparam int COMMON_SLOTS = 10;
  localparam int LED_COUNT = 48;
  localparam logic [5:0] GROUP_FIRST_LED = 6'h20;
  localparam logic [5:0] GROUP_LAST_LED = 6'h27;
  localparam logic [2:0] LAST_SUB_PHASE = 3'h7;

  typedef enum logic [1:0] {
    DUTY_OFF = 2'h0,
    DUTY_8 = 2'h1,
    DUTY_9 = 2'h2,
    DUTY_10 = 2'h3
  } duty_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SCAN = 2'b10
  } scan_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrStb;
    logic rdStb;
  } reg_req_t;

  typedef struct packed {
    logic [COMMON_SLOTS-1:0] commonLine;
    logic [SEG_LINES-1:0] segmentLine;
  } led_pins_t;

  function automatic logic [6:0] scan_divisor(input logic [1:0] code);
    case (code)
      2'h0: scan_divisor = DIV_CODE0;
      2'h1: scan_divisor = DIV_CODE1;
      2'h2: scan_divisor = DIV_CODE2;
      default: scan_divisor = DIV_CODE3;
    endcase
  endfunction : scan_divisor

endpackage : led_scan_pkg

/* File: rtl/scan_prescaler.sv */
`timescale 1ns/1ps
module scan_prescaler (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic fastRcTick,
  input wire logic [1:0] prescale,
  output logic scanTick
);
  import led_scan_pkg::*;

  logic [6:0] rcCount_ff;
  logic atEnd;

  // a shrinking divisor must not strand the counter above its end
  assign atEnd = (rcCount_ff >= scan_divisor(prescale) - 7'h01);
  assign scanTick = run && fastRcTick && atEnd;

  always_ff @(posedge sys_clk) begin
    if (!rst_b || !run) begin
      rcCount_ff <= 7'h00;
    end else if (fastRcTick) begin
      rcCount_ff <= atEnd ? 7'h00 : rcCount_ff + 7'h01;
    end
  end

endmodule : scan_prescaler

/* File: rtl/level_ramp.sv */
`timescale 1ns/1ps
module level_ramp (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [2:0] target,
  input wire logic smoothDis,
  input wire logic frameTick,
  output logic [2:0] level_ff
);
  import led_scan_pkg::*;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      level_ff <= BRIGHT_RST;
    end else if (smoothDis) begin
      level_ff <= target;
    end else if (frameTick && level_ff < target) begin
      level_ff <= level_ff + 3'h1;
    end else if (frameTick && level_ff > target) begin
      level_ff <= level_ff - 3'h1;
    end
  end

endmodule : level_ramp

/* File: rtl/led_matrix_scan_control.sv */
`timescale 1ns/1ps
// Operation
// - duty field off at 00, else selects duty
// - prescaler divides fast RC by 64/32/16/8
// - main level drives LEDs 0-31, 40-47
// - smoothing disable bit, clear means smooth
// - odd group level drives LEDs 33-39 odd
// - even group level drives LEDs 32-38 even
module led_matrix_scan_control (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire led_scan_pkg::reg_req_t regReq,
  output logic [7:0] rdData_ff,
  input wire logic fastRcTick,
  input wire logic [led_scan_pkg::LED_COUNT-1:0] ledOn,
  output led_scan_pkg::led_pins_t pins_ff
);
  import led_scan_pkg::*;

  logic [1:0] duty_ff;
  logic [1:0] psc_ff;
  logic hold_ff;
  logic [2:0] mainBright_ff;
  logic smoothDis_ff;
  logic [2:0] oddBright_ff;
  logic [2:0] evenBright_ff;
  scan_state_t state_ff;
  scan_state_t nxt_state;
  logic [2:0] subPhase_ff;
  logic [3:0] slot_ff;
  logic [3:0] slotCount;
  logic [2:0] segCount;
  logic scanTick;
  logic frameTick;
  logic [2:0] lvl [3];
  logic [2:0] tgt [3];
  logic [2:0] segLevel [SEG_LINES];
  logic [SEG_LINES-1:0] nxt_seg;
  logic wrMain;
  logic wrGroup;
  logic dutyNew;

  assign wrMain = regReq.wrStb && regReq.addr == MAIN_CTRL_ADDR;
  assign wrGroup = regReq.wrStb && regReq.addr == GROUP_BRIGHT_ADDR;
  assign dutyNew = wrMain && regReq.wrData[DUTY_POS +: 2] != duty_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      duty_ff <= DUTY_RST;
      psc_ff <= PSC_RST;
      hold_ff <= HOLD_RST;
      mainBright_ff <= BRIGHT_RST;
    end else if (wrMain) begin
      duty_ff <= regReq.wrData[DUTY_POS +: 2];
      psc_ff <= regReq.wrData[PSC_POS +: 2];
      hold_ff <= regReq.wrData[HOLD_POS];
      mainBright_ff <= regReq.wrData[MAIN_BRIGHT_POS +: 3];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      smoothDis_ff <= SMOOTH_DIS_RST;
      oddBright_ff <= BRIGHT_RST;
      evenBright_ff <= BRIGHT_RST;
    end else if (wrGroup) begin
      smoothDis_ff <= regReq.wrData[SMOOTH_DIS_POS];
      oddBright_ff <= regReq.wrData[ODD_BRIGHT_POS +: 3];
      evenBright_ff <= regReq.wrData[EVEN_BRIGHT_POS +: 3];
    end
  end

  // read data stand for one cycle only; unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !regReq.rdStb) begin
      rdData_ff <= 8'h00;
    end else if (regReq.addr == MAIN_CTRL_ADDR) begin
      rdData_ff <= {duty_ff, psc_ff, hold_ff, mainBright_ff};
    end else if (regReq.addr == GROUP_BRIGHT_ADDR) begin
      rdData_ff <= {smoothDis_ff, oddBright_ff, 1'h0, evenBright_ff};
    end else begin
      rdData_ff <= 8'h00;
    end
  end

  always_comb begin
    case (duty_ff)
      DUTY_8: begin
        slotCount = SLOTS_DUTY8;
        segCount = SEGS_DUTY8;
      end
      DUTY_9: begin
        slotCount = SLOTS_DUTY9;
        segCount = SEGS_DUTY9;
      end
      DUTY_10: begin
        slotCount = SLOTS_DUTY10;
        segCount = SEGS_DUTY10;
      end
      default: begin
        slotCount = SLOTS_DUTY8;
        segCount = 3'h0;
      end
    endcase
  end

  always_comb begin
    case (state_ff)
      ST_IDLE: nxt_state = (duty_ff != DUTY_OFF) ? ST_SCAN : ST_IDLE;
      ST_SCAN: nxt_state = (duty_ff == DUTY_OFF) ? ST_IDLE : ST_SCAN;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  scan_prescaler prescaler (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .run(state_ff == ST_SCAN),
    .fastRcTick(fastRcTick),
    .prescale(psc_ff),
    .scanTick(scanTick)
  );

  assign frameTick = scanTick && subPhase_ff == LAST_SUB_PHASE &&
                     slot_ff == slotCount - 4'h1;

  always_ff @(posedge sys_clk) begin
    // a new duty restarts the scan so no slot sits past the last one
    if (!rst_b || state_ff != ST_SCAN || dutyNew) begin
      subPhase_ff <= 3'h0;
      slot_ff <= 4'h0;
    end else if (scanTick) begin
      subPhase_ff <= subPhase_ff + 3'h1;
      if (subPhase_ff == LAST_SUB_PHASE) begin
        slot_ff <= (slot_ff >= slotCount - 4'h1) ? 4'h0 : slot_ff + 4'h1;
      end
    end
  end

  assign tgt[0] = mainBright_ff;
  assign tgt[1] = oddBright_ff;
  assign tgt[2] = evenBright_ff;

  // one smoothing ramp per brightness group
  for (genvar g = 0; g < 3; g++) begin : gen_ramp
    level_ramp ramp (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .target(tgt[g]),
      .smoothDis(smoothDis_ff),
      .frameTick(frameTick),
      .level_ff(lvl[g])
    );
  end

  // on-time grows with level: lit while sub-phase is at or below it
  for (genvar s = 0; s < SEG_LINES; s++) begin : gen_seg
    logic [5:0] ledNum;
    logic inGroup;
    assign ledNum = 6'(slot_ff * 6'h6 + 6'(s));
    assign inGroup = ledNum >= GROUP_FIRST_LED && ledNum <= GROUP_LAST_LED;
    assign segLevel[s] = !inGroup ? lvl[0] :
                         ledNum[0] ? lvl[1] : lvl[2];
    assign nxt_seg[s] = state_ff == ST_SCAN && 3'(s) < segCount &&
                        ledNum < 6'(LED_COUNT) && ledOn[ledNum] &&
                        subPhase_ff <= segLevel[s];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b || state_ff != ST_SCAN) begin
      pins_ff <= '0;
    end else begin
      pins_ff.commonLine <= COMMON_SLOTS'(1) << slot_ff;
      pins_ff.segmentLine <= nxt_seg;
    end
  end

  // checks
  logic [6:0] rcSeen_ff;
  logic measValid_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_b || wrMain || state_ff != ST_SCAN) begin
      rcSeen_ff <= 7'h00;
      measValid_ff <= 1'b0;
    end else if (scanTick) begin
      rcSeen_ff <= 7'h00;
      measValid_ff <= 1'b1;
    end else if (fastRcTick) begin
      rcSeen_ff <= rcSeen_ff + 7'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_OFF_DARK: assert property (
    duty_ff == DUTY_OFF ##1 duty_ff == DUTY_OFF |=> pins_ff == '0)
    else $error("pins driven while matrix is off");
  AST_SLOT_RANGE: assert property (
    state_ff == ST_SCAN |-> slot_ff < slotCount &&
      $countones(pins_ff.commonLine) <= 1)
    else $error("scan slot outside selected duty");
  AST_PSC_PERIOD: assert property (
    scanTick && measValid_ff && !wrMain |->
      rcSeen_ff == scan_divisor(psc_ff) - 7'h01)
    else $error("scan tick spacing differs from prescaler");
  AST_MAIN_WRITE: assert property (
    wrMain |=> mainBright_ff == $past(regReq.wrData[2:0]) &&
      duty_ff == $past(regReq.wrData[7:6]))
    else $error("main control write not stored");
  AST_ODD_WRITE: assert property (
    wrGroup |=> oddBright_ff == $past(regReq.wrData[6:4]))
    else $error("odd group level not stored");
  AST_EVEN_WRITE: assert property (
    wrGroup |=> evenBright_ff == $past(regReq.wrData[2:0]))
    else $error("even group level not stored");
  AST_NO_SMOOTH: assert property (
    smoothDis_ff |=> lvl[0] == $past(mainBright_ff))
    else $error("level did not jump with smoothing off");
  AST_SMOOTH_HOLD: assert property (
    !smoothDis_ff && !frameTick |=> $stable(lvl[0]))
    else $error("smoothed level moved outside frame end");
  AST_ON_TIME: assert property (
    pins_ff.segmentLine[0] |-> $past(subPhase_ff) <= $past(segLevel[0]))
    else $error("segment lit beyond its level");

  COV_FRAME10: cover property (frameTick && duty_ff == DUTY_10);
  COV_RAMP: cover property (!smoothDis_ff && frameTick &&
    lvl[0] != mainBright_ff);
  COV_GROUP_LIT: cover property (state_ff == ST_SCAN &&
    slot_ff == 4'h5 && pins_ff.segmentLine[3]);

endmodule : led_matrix_scan_control

/* File: bench/led_matrix_model.sv */
`timescale 1ns/1ps
// passive matrix: times how long one LED's common runs and how long it is lit
module led_matrix_model (
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic [5:0] probe,
  input wire led_scan_pkg::led_pins_t pins,
  output logic [9:0] slotLen,
  output logic [9:0] litLen,
  output logic [1:0] runs,
  output logic [3:0] maxSlot
);
  import led_scan_pkg::*;
  logic [9:0] runCnt;
  logic [9:0] litCnt;
  logic [3:0] slotIdx;
  logic [2:0] segIdx;
  assign slotIdx = 4'(probe / 6'h6);
  assign segIdx = 3'(probe % 6'h6);
  always @(posedge sys_clk) begin
    if (clr) begin
      runs <= 2'h0;
      maxSlot <= 4'h0;
      runCnt <= 10'h0;
      litCnt <= 10'h0;
    end else begin
      for (int i = 0; i < COMMON_SLOTS; i++) begin
        if (pins.commonLine[i] && 4'(i) > maxSlot) maxSlot <= 4'(i);
      end
      if (pins.commonLine[slotIdx]) begin
        runCnt <= runCnt + 10'h1;
        litCnt <= litCnt + 10'(pins.segmentLine[segIdx]);
      end else if (runCnt != 10'h0) begin
        slotLen <= runCnt;
        litLen <= litCnt;
        runCnt <= 10'h0;
        litCnt <= 10'h0;
        if (runs != 2'h3) runs <= runs + 2'h1;
      end
    end
  end
endmodule : led_matrix_model

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  import led_scan_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic fastRcTick = 1'b0;
  reg_req_t regReq = '0;
  logic [47:0] ledOn = '0;
  logic [7:0] rdData_ff;
  led_pins_t pins_ff;
  logic clr = 1'b0;
  logic [5:0] probe = 6'h0;
  logic [9:0] slotLen, litLen;
  logic [1:0] runs;
  logic [3:0] maxSlot;
  logic [7:0] d1, d2;
  logic [2:0] lv [3];
  logic [5:0] pr [4] = '{6'h00, 6'h28, 6'h21, 6'h20};
  int grp [4] = '{0, 0, 1, 2};
  int miscompares = 0;
  int cmpCount = 0;
  int cycles = 0;

  led_matrix_scan_control i_led_matrix_scan_control (.sys_clk(sys_clk),
    .rst_b(rst_b), .regReq(regReq), .rdData_ff(rdData_ff),
    .fastRcTick(fastRcTick), .ledOn(ledOn), .pins_ff(pins_ff));
  led_matrix_model i_led_matrix_model (.sys_clk(sys_clk), .clr(clr),
    .probe(probe), .pins(pins_ff), .slotLen(slotLen), .litLen(litLen),
    .runs(runs), .maxSlot(maxSlot));

  always #20 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge sys_clk);
    regReq.wrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regReq <= '{addr: a, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge sys_clk);
    regReq.rdStb <= 1'b0;
    #1 chk(16'(rdData_ff), 16'(exp));
  endtask : rd

  // waits for two runs of the probe's common line to end; the first may be partial
  task automatic meas(input logic [5:0] p, input logic [9:0] expLit);
    int n;
    n = 0;
    probe <= p;
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    #1;
    while (runs < 2'h2 && n < 12000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= 12000) miscompares++;
    chk(16'(litLen), 16'(expLit));
  endtask : meas

  function automatic logic [9:0] divOf(input logic [1:0] c);
    return 10'(8'h40 >> c);
  endfunction : divOf

  initial begin
    void'($urandom(32'h6C7C));
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(MAIN_CTRL_ADDR, 8'h04);
    rd(GROUP_BRIGHT_ADDR, 8'h44);
    rd(8'hB3, 8'h00);
    chk(pins_ff, 16'h0000);
    fastRcTick <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      d1 = 8'($urandom) & 8'hF7;
      d2 = 8'($urandom);
      wr(MAIN_CTRL_ADDR, d1);
      wr(GROUP_BRIGHT_ADDR, d2);
      wr(8'hB0, 8'hFF);
      rd(MAIN_CTRL_ADDR, d1);
      rd(GROUP_BRIGHT_ADDR, d2 & 8'hF7);
    end
    ledOn <= {16'($urandom), 32'($urandom)} | 48'h0301_0000_0011;
    wr(GROUP_BRIGHT_ADDR, 8'hF7);
    for (int p = 0; p < 4; p++) begin
      wr(MAIN_CTRL_ADDR, {2'h3, 2'(p), 4'h7});
      meas(6'h0, 10'h8 * divOf(2'(p)));
      chk(16'(slotLen), 16'(10'h8 * divOf(2'(p))));
    end
    for (int d = 1; d < 4; d++) begin
      wr(MAIN_CTRL_ADDR, {2'(d), 6'h37});
      meas(6'h4, (d == 1) ? 10'h0 : 10'h40);
      chk(16'(maxSlot), 16'(6 + d));
    end
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 3; k++)
        lv[k] = (i < 2) ? 3'(7 * i) : 3'($urandom);
      wr(MAIN_CTRL_ADDR, {4'hF, 1'b0, lv[0]});
      wr(GROUP_BRIGHT_ADDR, {1'b1, lv[1], 1'b0, lv[2]});
      for (int q = 0; q < 4; q++)
        meas(pr[q], 10'h8 * (10'(lv[grp[q]]) + 10'h1));
    end
    wr(MAIN_CTRL_ADDR, 8'hF7);
    wr(GROUP_BRIGHT_ADDR, 8'h44);
    meas(6'h0, 10'h40);
    // written early in slot 1: two frame ends pass before the second run
    wr(MAIN_CTRL_ADDR, 8'hF0);
    meas(6'h0, 10'h30);
    chk(16'(litLen > 10'h8), 16'h1);
    repeat (7000) @(posedge sys_clk);
    meas(6'h0, 10'h8);
    wr(MAIN_CTRL_ADDR, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1 chk(pins_ff, 16'h0000);
    test_done();
  end
endmodule : tb
